// ### rrne_exec.sv
// Decode and execute for no-op, return-from-interrupt, return-literal and rotate-left
`timescale 1ns/1ps
module rrne_exec
   import rrne_pkg::*;
(
   input  wire logic                 clk,          // 200 MHz core clock
   input  wire logic                 rst_n,        // Synchronous reset, active low
   input  wire logic [13:0]          instr,        // Opcode, valid when instr_valid
   input  wire logic                 instr_valid,  // Opcode presented this cycle
   input  wire logic [RRNE_PC_W-1:0] stack_top,    // Top of stack value
   input  wire logic [7:0]           file_rdata,   // Addressed file register contents
   output logic                      instr_ready,  // Core can take an opcode
   output logic                      stack_pop,    // Pop pulse to stack
   output logic [6:0]                file_addr,    // File register address
   output logic [7:0]                file_wdata,   // File register write data
   output logic                      file_we,      // File write pulse
   output logic [RRNE_PC_W-1:0]      pc,           // Program counter
   output logic [7:0]                w_reg,        // Working register
   output logic                      carry,        // Carry flag
   output logic [7:0]                int_ctrl,     // Interrupt control register
   output logic                      illegal       // Unhandled opcode pulse
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   rrne_state_type state_ff;           // Fetch or second cycle
   rrne_state_type nxt_state;          // Next state
   logic [RRNE_PC_W-1:0] pc_ff;        // Program counter
   logic [7:0]  w_ff;                  // Working register
   logic        c_ff;                  // Carry flag
   logic [7:0]  intc_ff;               // Interrupt control
   logic        pop_ff;                // Stack pop pulse
   logic        fwe_ff;                // File write pulse
   logic [6:0]  faddr_ff;              // Write address
   logic [7:0]  fdata_ff;              // Write data
   logic        ill_ff;                // Illegal pulse
   logic        ready_ff;              // Ready output
   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   logic dec_nop;                      // No-op match
   logic dec_reti;                     // Interrupt return match
   logic dec_retl;                     // Literal return match
   logic dec_rlc;                      // Rotate match
   logic take;                         // Opcode accepted this cycle
   logic [7:0] rot_res;                // Rotate result
   logic       rot_c;                  // Rotate carry out

   // The file port is busy with a write-back for one cycle after a rotate to f,
   // so nothing is taken then; otherwise a following rotate would read the wrong register
   assign take     = instr_valid && (state_ff == RRNE_FETCH) && !fwe_ff;
   assign dec_nop  = (instr & RRNE_NOP_MASK) == RRNE_NOP_OPC;
   assign dec_reti = instr == RRNE_RETI_OPC;
   assign dec_retl = instr[13:RRNE_RETL_HI_POS] == RRNE_RETL_HI;
   assign dec_rlc  = instr[13:RRNE_HI6_POS] == RRNE_RLC_HI;

   // Read address goes straight out so file_rdata returns in the same cycle;
   // during a write-back the held address of the rotate takes the port
   assign file_addr = fwe_ff ? faddr_ff : instr[6:0];

   rrne_rot u_rot
   (
      .src_val   (file_rdata),
      .carry_in  (c_ff),
      .result    (rot_res),
      .carry_out (rot_c)
   );

   // ------------------------------------------------------------
   // Sequencer: two-cycle returns hold a second cycle
   // ------------------------------------------------------------
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         RRNE_FETCH:
            if (take && (dec_reti || dec_retl))
               nxt_state = RRNE_SECOND;
         RRNE_SECOND:
            nxt_state = RRNE_FETCH;        // Refill cycle done
         default:
            nxt_state = RRNE_FETCH;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         state_ff <= RRNE_FETCH;
      else
         state_ff <= nxt_state;
   end

   // Ready drops during the second cycle of a return and during a write-back
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         ready_ff <= 1'b0;
      else
         ready_ff <= (nxt_state == RRNE_FETCH) && !(take && dec_rlc && instr[RRNE_DEST_POS]);
   end

   // ------------------------------------------------------------
   // Program counter and stack pop
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pc_ff  <= RRNE_PC_RST;
         pop_ff <= 1'b0;
      end
      else
      begin
         pop_ff <= 1'b0;
         if (take)
         begin
            if (dec_reti || dec_retl)
            begin
               pc_ff  <= stack_top;
               pop_ff <= 1'b1;
            end
            else
               pc_ff <= pc_ff + 13'h0001;
         end
      end
   end

   // ------------------------------------------------------------
   // Working register
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         w_ff <= RRNE_W_RST;
      else if (take && dec_retl)
         w_ff <= instr[7:0];
      else if (take && dec_rlc && !instr[RRNE_DEST_POS])
         w_ff <= rot_res;
   end

   // ------------------------------------------------------------
   // Carry: only rotate touches it
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         c_ff <= 1'b0;
      else if (take && dec_rlc)
         c_ff <= rot_c;
   end

   // ------------------------------------------------------------
   // File write-back
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         fwe_ff   <= 1'b0;
         faddr_ff <= 7'h00;
         fdata_ff <= 8'h00;
      end
      else
      begin
         fwe_ff <= take && dec_rlc && instr[RRNE_DEST_POS];
         if (take && dec_rlc)
         begin
            faddr_ff <= instr[6:0];
            fdata_ff <= rot_res;
         end
      end
   end

   // ------------------------------------------------------------
   // Interrupt control: global enable set on interrupt return
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         intc_ff <= RRNE_INTC_RST;
      else if (take && dec_reti)
         intc_ff[RRNE_GIE_POS] <= 1'b1;
   end

   // Other opcodes belong to neighbouring units; flag them
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         ill_ff <= 1'b0;
      else
         ill_ff <= take && !(dec_nop || dec_reti || dec_retl || dec_rlc);
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign instr_ready = ready_ff;
   assign stack_pop   = pop_ff;
   assign file_wdata  = fdata_ff;
   assign file_we     = fwe_ff;
   assign pc          = pc_ff;
   assign w_reg       = w_ff;
   assign carry       = c_ff;
   assign int_ctrl    = intc_ff;
   assign illegal     = ill_ff;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_reti_pc_pop: assert property (@(posedge clk) disable iff (!rst_n)
      take && dec_reti |=> pc_ff == $past(stack_top) && pop_ff)
      else $error("interrupt return did not pop into pc");
   chk_reti_gie: assert property (@(posedge clk) disable iff (!rst_n)
      take && dec_reti |=> intc_ff[RRNE_GIE_POS])
      else $error("global enable not set");
   chk_reti_two_cyc: assert property (@(posedge clk) disable iff (!rst_n)
      take && dec_reti |=> !ready_ff ##1 ready_ff && $stable(c_ff))
      else $error("interrupt return not two cycles");
   chk_retl_w_load: assert property (@(posedge clk) disable iff (!rst_n)
      take && dec_retl |=> w_ff == $past(instr[7:0]) && c_ff == $past(c_ff) && !ready_ff)
      else $error("literal return wrong");
   chk_rlc_carry: assert property (@(posedge clk) disable iff (!rst_n)
      take && dec_rlc |=> c_ff == $past(file_rdata[7]) && ready_ff == !$past(instr[RRNE_DEST_POS]))
      else $error("rotate carry wrong");
   chk_rlc_wr_addr: assert property (@(posedge clk) disable iff (!rst_n)
      take && dec_rlc && instr[RRNE_DEST_POS] |=> file_we && file_addr == $past(instr[6:0]))
      else $error("rotate write-back address wrong");
   chk_rlc_to_w: assert property (@(posedge clk) disable iff (!rst_n)
      take && dec_rlc && !instr[7] |=> w_ff == {$past(file_rdata[6:0]), $past(c_ff)} && !fwe_ff)
      else $error("rotate to w wrong");
   chk_rlc_to_f: assert property (@(posedge clk) disable iff (!rst_n)
      take && dec_rlc && instr[7] |=> fwe_ff && fdata_ff == {$past(file_rdata[6:0]), $past(c_ff)}
         && w_ff == $past(w_ff))
      else $error("rotate to file wrong");
   chk_nop_pc_only: assert property (@(posedge clk) disable iff (!rst_n)
      take && dec_nop |=> pc_ff == $past(pc_ff) + 13'h0001 && $stable(w_ff) && $stable(c_ff) && !fwe_ff)
      else $error("no-op changed state");
endmodule : rrne_exec

// ### rrne_pkg.sv
// Package: encodings, field positions and reset values for the return/rotate/no-op executor
package rrne_pkg;
   // ------------------------------------------------------------
   // Opcode encodings
   // ------------------------------------------------------------
   localparam logic [13:0] RRNE_RETI_OPC     = 14'h0009;   // Return from interrupt
   localparam logic [13:0] RRNE_NOP_MASK     = 14'h3F9F;   // Bits 6:5 are don't-care
   localparam logic [13:0] RRNE_NOP_OPC      = 14'h0000;   // No operation
   localparam logic [3:0]  RRNE_RETL_HI      = 4'hD;       // Top nibble 11 01, bits 9:8 ignored
   localparam int          RRNE_RETL_HI_POS  = 10;         // Low bit of that nibble
   localparam logic [5:0]  RRNE_RLC_HI       = 6'h0D;      // 00 1101
   localparam int          RRNE_HI6_POS      = 8;          // Low bit of six-bit class field
   localparam int          RRNE_DEST_POS     = 7;          // Destination select bit
   localparam int          RRNE_GIE_POS      = 7;          // Global enable in interrupt control
   // ------------------------------------------------------------
   // Widths and reset values
   // ------------------------------------------------------------
   localparam int          RRNE_PC_W         = 13;         // Program counter width
   localparam logic [7:0]  RRNE_W_RST        = 8'h00;      // Working register after reset
   localparam logic [7:0]  RRNE_INTC_RST     = 8'h00;      // Interrupt control after reset
   localparam logic [12:0] RRNE_PC_RST       = 13'h0000;   // Reset vector
   // Execution state
   typedef enum logic [0:0] {RRNE_FETCH, RRNE_SECOND} rrne_state_type;
endpackage : rrne_pkg

// ### rrne_rot.sv
// Rotate-left-through-carry datapath
`timescale 1ns/1ps
module rrne_rot
   import rrne_pkg::*;
(
   input  wire logic [7:0] src_val,    // Operand from file register
   input  wire logic       carry_in,   // Current carry
   output logic      [7:0] result,     // Rotated value
   output logic            carry_out   // New carry
);
   // ------------------------------------------------------------
   // Pure combinational rotate
   // ------------------------------------------------------------
   always_comb
   begin
      result    = {src_val[6:0], carry_in};
      carry_out = src_val[7];
   end
endmodule : rrne_rot

// ### tb_top.sv
// Self-checking testbench for the return/rotate/no-op executor
`timescale 1ns/1ps
module tb_top
   import rrne_pkg::*;
;
   // ------------------------------------------------------------
   // Stimulus, observed signals and score
   // ------------------------------------------------------------
   logic                 clk;          // 200 MHz core clock
   logic                 rst_n;        // Synchronous reset, active low
   logic [13:0]          instr;        // Opcode under test
   logic                 instr_valid;  // Opcode offered
   logic [RRNE_PC_W-1:0] stack_top;    // Stack value handed to returns
   logic [7:0]           file_rdata;   // File operand, held by the bench
   logic                 instr_ready, stack_pop, file_we, carry, illegal;
   logic [6:0]           file_addr;    // Observed file address
   logic [7:0]           file_wdata, w_reg, int_ctrl;
   logic [RRNE_PC_W-1:0] pc;           // Observed program counter
   logic [RRNE_PC_W-1:0] exp_pc;       // Expected program counter
   int                   err_total;    // Mismatches seen
   int                   n_checks;     // Comparisons made

   rrne_exec u_dut (.clk(clk), .rst_n(rst_n), .instr(instr), .instr_valid(instr_valid),
      .stack_top(stack_top), .file_rdata(file_rdata), .instr_ready(instr_ready),
      .stack_pop(stack_pop), .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we),
      .pc(pc), .w_reg(w_reg), .carry(carry), .int_ctrl(int_ctrl), .illegal(illegal));

   // ------------------------------------------------------------
   // Compare tasks, one per width of result
   // ------------------------------------------------------------
   task cmp_bit(input string what, input logic exp, input logic got);
      n_checks++;
      if (got !== exp)
      begin
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
         err_total++;
      end
   endtask : cmp_bit

   task cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
         err_total++;
      end
   endtask : cmp_byte

   task cmp_pc(input logic [RRNE_PC_W-1:0] exp);
      n_checks++;
      if (pc !== exp)
      begin
         $display("mismatch pc expected %0h seen %0h", exp, pc);
         err_total++;
      end
   endtask : cmp_pc

   // Offer one opcode; returns 1 ns after the taking edge, so results are settled
   task issue(input logic [13:0] op);
      @(posedge clk);
      #1;
      instr       = op;
      instr_valid = 1'b1;
      @(posedge clk);
      #1;
      instr_valid = 1'b0;
   endtask : issue

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Both don't-care bits of the no-op swept; nothing but pc may move
   task t_nop;
      for (int i = 0; i < 4; i++)
      begin
         issue({7'h00, i[1:0], 5'h00});
         exp_pc = exp_pc + 1'b1;
         cmp_pc(exp_pc);
         cmp_byte("w_reg", 8'h00, w_reg);
         cmp_bit("carry", 1'b0, carry);
         cmp_bit("file_we", 1'b0, file_we | stack_pop | illegal);
      end
      issue(14'h0062);                                      // Not a no-op: bit 1 set
      exp_pc = exp_pc + 1'b1;
      cmp_bit("illegal", 1'b1, illegal);
      cmp_pc(exp_pc);
   endtask : t_nop

   // Top address, d=0 then d=1 with the carry fed back in
   task t_rotate;
      file_rdata = 8'hE6;
      issue({RRNE_RLC_HI, 1'b0, 7'h7F});
      exp_pc = exp_pc + 1'b1;
      cmp_byte("file_addr", 8'h7F, {1'b0, file_addr});
      cmp_byte("w_reg", 8'hCC, w_reg);
      cmp_bit("carry", 1'b1, carry);
      cmp_bit("file_we", 1'b0, file_we);
      cmp_pc(exp_pc);
      file_rdata = 8'h55;
      issue({RRNE_RLC_HI, 1'b1, 7'h05});
      exp_pc = exp_pc + 1'b1;
      cmp_bit("file_we", 1'b1, file_we);
      cmp_byte("file_wdata", 8'hAB, file_wdata);
      cmp_bit("carry", 1'b0, carry);
      cmp_byte("w_reg", 8'hCC, w_reg);
      cmp_pc(exp_pc);
      instr = 14'h0000;                                     // Next opcode already on the bus
      #1;
      cmp_byte("file_addr", 8'h05, {1'b0, file_addr});
      cmp_bit("instr_ready", 1'b0, instr_ready);
   endtask : t_rotate

   // Literal return with ignored bits both ways; an opcode in the second cycle is refused
   task t_return_literal_op(input logic [1:0] xx, input logic [7:0] k, input logic [RRNE_PC_W-1:0] top_of_stack);
      stack_top = top_of_stack;
      @(posedge clk);
      #1;
      instr       = {RRNE_RETL_HI, xx, k};
      instr_valid = 1'b1;
      @(posedge clk);
      #1;
      instr       = 14'h0000;                               // No-op offered too early, valid kept high
      cmp_byte("w_reg", k, w_reg);
      cmp_pc(top_of_stack);
      cmp_bit("stack_pop", 1'b1, stack_pop);
      cmp_bit("instr_ready", 1'b0, instr_ready);
      cmp_byte("int_ctrl", 8'h00, int_ctrl);
      @(posedge clk);
      #1;
      instr_valid = 1'b0;
      @(posedge clk);
      #1;
      cmp_pc(top_of_stack);
      cmp_bit("stack_pop", 1'b0, stack_pop);
      cmp_bit("carry", 1'b0, carry);
      exp_pc = top_of_stack;
   endtask : t_return_literal_op

   // Interrupt return: pop, global enable set, flags and W untouched
   task t_reti;
      stack_top = 13'h1ABC;
      issue(14'h0009);
      cmp_pc(13'h1ABC);
      cmp_bit("stack_pop", 1'b1, stack_pop);
      cmp_byte("int_ctrl", 8'h80, int_ctrl);
      cmp_bit("instr_ready", 1'b0, instr_ready);
      cmp_bit("carry", 1'b0, carry);
      cmp_byte("w_reg", 8'hFF, w_reg);
   endtask : t_reti

   // ------------------------------------------------------------
   // Clock, main sequence, watchdog and verdict
   // ------------------------------------------------------------
   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial
   begin
      {rst_n, instr, instr_valid, stack_top, file_rdata} = '0;
      {err_total, n_checks, exp_pc} = '0;
      repeat (12) @(posedge clk);
      #1;
      rst_n = 1'b1;
      cmp_pc(RRNE_PC_RST);
      cmp_byte("int_ctrl", RRNE_INTC_RST, int_ctrl);
      t_nop();
      t_rotate();
      t_return_literal_op(2'b00, 8'h00, 13'h0123);
      t_return_literal_op(2'b11, 8'hFF, 13'h1FFF);
      t_reti();
      end_of_test();
   end

   // Whole run is well under 200 cycles; this cuts a hang short
   initial
   begin
      #5000;
      err_total++;
      end_of_test();
   end
endmodule : tb_top
